// ==== src/jtdec_cfg.svh ====
// constants of the tap instruction decoder
`ifndef JTDEC_CFG_SVH
`define JTDEC_CFG_SVH
`define JTDEC_IR_W 5
`define JTDEC_DR_W 32
`define JTDEC_OP_EXTEST 5'h00
`define JTDEC_OP_SAMPLE 5'h01
`define JTDEC_OP_USER_A 5'h02
`define JTDEC_OP_USER_B 5'h03
`define JTDEC_OP_CFG_RD 5'h04
`define JTDEC_OP_CFG_WR 5'h05
`define JTDEC_OP_INTEST 5'h07
`define JTDEC_OP_UCODE 5'h08
`define JTDEC_OP_IDENT 5'h09
`define JTDEC_OP_FLOAT 5'h0a
`define JTDEC_OP_START 5'h0c
`define JTDEC_OP_BYPASS 5'h1f
`define JTDEC_IR_RST_VAL 5'h09
`define JTDEC_IR_CAP_LSB 2'h1
`define JTDEC_IDENT_DEF 32'h1234_5671
`define JTDEC_UCODE_DEF 32'hffff_ffff
`endif

// ==== src/jtdec_pkg.sv ====
// types of the tap instruction decoder
package jtdec_pkg;
	typedef enum logic [15:0] {
		TLR = 16'h0001, RTI = 16'h0002, SEL_DR = 16'h0004, CAP_DR = 16'h0008,
		SH_DR = 16'h0010, EX1_DR = 16'h0020, PAU_DR = 16'h0040, EX2_DR = 16'h0080,
		UPD_DR = 16'h0100, SEL_IR = 16'h0200, CAP_IR = 16'h0400, SH_IR = 16'h0800,
		EX1_IR = 16'h1000, PAU_IR = 16'h2000, EX2_IR = 16'h4000, UPD_IR = 16'h8000
	} jtdec_state_t;
	typedef struct packed {
		logic bscan;
		logic userA;
		logic userB;
		logic cfgRd;
		logic cfgWr;
		logic ucode;
		logic ident;
		logic bypass;
		logic floatOut;
		logic start;
	} jtdec_sel_t;
endpackage

// ==== src/jtdec_tap.sv ====
// tap controller, instruction register, opcode decoder and data register routing
`include "jtdec_cfg.svh"

// Behaviour
// - sixteen-state controller stepped by mode select on each rising test-clock edge
// - serial input feeds at most one register, chosen by state and instruction
// - serial input sampled into the selected register on rising edge
// - serial output changes only on falling test-clock edge
// - output driver enabled only during instruction or data shift
// - output source chosen from state and held instruction
// - separate data-scan and instruction-scan sequences
// - instructions are five bits; decoded to select the operation
// - 00000, 00001, 00111 select the boundary-scan register
// - 00010 and 00011 select the two user scan registers
// - 00100 readback, 00101 write, both via configuration data register
// - 01000 shifts user code, 01001 shifts identification code
// - 01010 floats all outputs and selects the bypass register
// - 01100 steps startup from test clock only if so configured
// - 11111 is bypass; unlisted opcodes are reserved, treated as bypass
// - user register instructions refused before configuration
// - boundary-scan mode works regardless of mode pins and overrides them
// - instruction capture loads device status, otherwise holds opcode
// - bypass is one flip-flop, cleared in update-data state
// - configuration data register is thirty-two bits
module jtdec_tap #(
	parameter logic [31:0] IDENT_CODE = `JTDEC_IDENT_DEF, // arbitrary value
	parameter int CHAIN_W = 3 // boundary chain length
) (
	input wire logic clk, // system clock, 125 MHz
	input wire logic sys_rst, // asynchronous reset, active high
	input wire logic tck, // test clock
	input wire logic tms, // test mode select
	input wire logic tdi, // test data in
	output logic tdoOut, // test data out value
	output logic tdoOe, // test data out enable
	input wire logic configDone, // device configured, system domain
	input wire logic startClkIsTck, // startup clock source is test clock
	input wire logic [31:0] user_code_instr, // user-programmed code
	input wire logic [2:0] devStatus, // status captured into instruction register
	input wire logic userATdo, // user scan reg a serial out
	input wire logic userBTdo, // user scan reg b serial out
	input wire logic [CHAIN_W-1:0] bscanCapture, // boundary capture values
	output logic [CHAIN_W-1:0] bscanUpdate, // boundary update latch
	output logic [`JTDEC_DR_W-1:0] cfgWord, // word written to config bus
	output logic cfgWordStb, // toggles per written word, tck domain
	output logic userASel, // user scan reg a selected
	output logic userBSel, // user scan reg b selected
	output logic shiftDr, // data shift in progress
	output logic updateDr, // update-data state
	output logic floatOutputs, // all device outputs forced float
	output logic bscanMode, // boundary mode overrides mode pins
	output logic startupStep, // startup sequence clock enable
	output logic tapReset, // controller in test-logic-reset
	output logic configDoneSys // configured flag, system domain copy
);
	// ------------------------------------------------------------
	// configured flag crossing into the test-clock domain
	// ------------------------------------------------------------
	logic cfgSysReg;
	logic cfgMeta_reg;
	logic cfgSync_reg;
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
			cfgSysReg <= 1'b0;
		else
			cfgSysReg <= configDone;
	assign configDoneSys = cfgSysReg;
	// level crossing: two flops, only the second is read
	always_ff @(posedge tck or posedge sys_rst)
		if (sys_rst)
		begin
			cfgMeta_reg <= 1'b0;
			cfgSync_reg <= 1'b0;
		end
		else
		begin
			cfgMeta_reg <= cfgSysReg;
			cfgSync_reg <= cfgMeta_reg;
		end

	// ------------------------------------------------------------
	// controller
	// ------------------------------------------------------------
	jtdec_pkg::jtdec_state_t state_reg;
	jtdec_pkg::jtdec_state_t state_next;
	always_comb
	begin
		case (state_reg)
			jtdec_pkg::TLR:
				if (tms)
					state_next = jtdec_pkg::TLR;
				else
					state_next = jtdec_pkg::RTI;
			jtdec_pkg::RTI:
				if (tms)
					state_next = jtdec_pkg::SEL_DR;
				else
					state_next = jtdec_pkg::RTI;
			jtdec_pkg::SEL_DR:
				if (tms)
					state_next = jtdec_pkg::SEL_IR;
				else
					state_next = jtdec_pkg::CAP_DR;
			jtdec_pkg::CAP_DR:
				if (tms)
					state_next = jtdec_pkg::EX1_DR;
				else
					state_next = jtdec_pkg::SH_DR;
			jtdec_pkg::SH_DR:
				if (tms)
					state_next = jtdec_pkg::EX1_DR;
				else
					state_next = jtdec_pkg::SH_DR;
			jtdec_pkg::EX1_DR:
				if (tms)
					state_next = jtdec_pkg::UPD_DR;
				else
					state_next = jtdec_pkg::PAU_DR;
			jtdec_pkg::PAU_DR:
				if (tms)
					state_next = jtdec_pkg::EX2_DR;
				else
					state_next = jtdec_pkg::PAU_DR;
			jtdec_pkg::EX2_DR:
				if (tms)
					state_next = jtdec_pkg::UPD_DR;
				else
					state_next = jtdec_pkg::SH_DR;
			jtdec_pkg::UPD_DR:
				if (tms)
					state_next = jtdec_pkg::SEL_DR;
				else
					state_next = jtdec_pkg::RTI;
			jtdec_pkg::SEL_IR:
				if (tms)
					state_next = jtdec_pkg::TLR;
				else
					state_next = jtdec_pkg::CAP_IR;
			jtdec_pkg::CAP_IR:
				if (tms)
					state_next = jtdec_pkg::EX1_IR;
				else
					state_next = jtdec_pkg::SH_IR;
			jtdec_pkg::SH_IR:
				if (tms)
					state_next = jtdec_pkg::EX1_IR;
				else
					state_next = jtdec_pkg::SH_IR;
			jtdec_pkg::EX1_IR:
				if (tms)
					state_next = jtdec_pkg::UPD_IR;
				else
					state_next = jtdec_pkg::PAU_IR;
			jtdec_pkg::PAU_IR:
				if (tms)
					state_next = jtdec_pkg::EX2_IR;
				else
					state_next = jtdec_pkg::PAU_IR;
			jtdec_pkg::EX2_IR:
				if (tms)
					state_next = jtdec_pkg::UPD_IR;
				else
					state_next = jtdec_pkg::SH_IR;
			jtdec_pkg::UPD_IR:
				if (tms)
					state_next = jtdec_pkg::SEL_DR;
				else
					state_next = jtdec_pkg::RTI;
			default: state_next = jtdec_pkg::TLR;
		endcase
	end
	// tms comes from the tester on tck itself, so it is sampled directly
	always_ff @(posedge tck or posedge sys_rst)
		if (sys_rst)
			state_reg <= jtdec_pkg::TLR;
		else
			state_reg <= state_next;

	wire inTlr = (state_reg == jtdec_pkg::TLR);
	wire inCapDr = (state_reg == jtdec_pkg::CAP_DR);
	wire inShDr = (state_reg == jtdec_pkg::SH_DR);
	wire inUpdDr = (state_reg == jtdec_pkg::UPD_DR);
	wire inCapIr = (state_reg == jtdec_pkg::CAP_IR);
	wire inShIr = (state_reg == jtdec_pkg::SH_IR);
	wire inUpdIr = (state_reg == jtdec_pkg::UPD_IR);

	// ------------------------------------------------------------
	// instruction register
	// ------------------------------------------------------------
	logic [`JTDEC_IR_W-1:0] irShift_reg;
	logic [`JTDEC_IR_W-1:0] irHold_reg;
	wire [`JTDEC_IR_W-1:0] irShiftNext = inCapIr ? {devStatus, `JTDEC_IR_CAP_LSB}
		: inShIr ? {tdi, irShift_reg[`JTDEC_IR_W-1:1]} : irShift_reg;
	always_ff @(posedge tck or posedge sys_rst)
		if (sys_rst)
			irShift_reg <= `JTDEC_IR_RST_VAL;
		else
			irShift_reg <= irShiftNext;
	// held opcode changes only on update; reset falls back to identification
	always_ff @(negedge tck or posedge sys_rst)
		if (sys_rst)
			irHold_reg <= `JTDEC_IR_RST_VAL;
		else if (inTlr)
			irHold_reg <= `JTDEC_IR_RST_VAL;
		else if (inUpdIr)
			irHold_reg <= irShift_reg;

	// ------------------------------------------------------------
	// opcode decoder
	// ------------------------------------------------------------
	wire opBscan = (irHold_reg == `JTDEC_OP_EXTEST) || (irHold_reg == `JTDEC_OP_SAMPLE)
		|| (irHold_reg == `JTDEC_OP_INTEST);
	wire opUserA = (irHold_reg == `JTDEC_OP_USER_A) && cfgSync_reg;
	wire opUserB = (irHold_reg == `JTDEC_OP_USER_B) && cfgSync_reg;
	wire opCfgRd = (irHold_reg == `JTDEC_OP_CFG_RD);
	wire opCfgWr = (irHold_reg == `JTDEC_OP_CFG_WR);
	wire opUcode = (irHold_reg == `JTDEC_OP_UCODE);
	wire opIdent = (irHold_reg == `JTDEC_OP_IDENT);
	wire opFloat = (irHold_reg == `JTDEC_OP_FLOAT);
	wire opStart = (irHold_reg == `JTDEC_OP_START);
	jtdec_pkg::jtdec_sel_t sel;
	assign sel.bscan = opBscan;
	assign sel.userA = opUserA;
	assign sel.userB = opUserB;
	assign sel.cfgRd = opCfgRd;
	assign sel.cfgWr = opCfgWr;
	assign sel.ucode = opUcode;
	assign sel.ident = opIdent;
	assign sel.floatOut = opFloat;
	assign sel.start = opStart;
	// reserved opcodes and refused user opcodes fall to bypass
	assign sel.bypass = !(opBscan || opUserA || opUserB || opCfgRd || opCfgWr
		|| opUcode || opIdent || opStart);

	// ------------------------------------------------------------
	// data registers
	// ------------------------------------------------------------
	logic bypass_reg;
	logic [`JTDEC_DR_W-1:0] dr32_reg;
	logic [CHAIN_W-1:0] bsc_reg;
	wire use32 = sel.cfgRd || sel.cfgWr || sel.ucode || sel.ident;
	wire [`JTDEC_DR_W-1:0] dr32Cap = sel.ident ? IDENT_CODE
		: sel.ucode ? user_code_instr : dr32_reg;
	always_ff @(posedge tck or posedge sys_rst)
		if (sys_rst)
		begin
			bypass_reg <= 1'b0;
			dr32_reg <= '0;
			bsc_reg <= '0;
		end
		else
		begin
			// tdi reaches only the register selected by the held opcode
			if (inUpdDr)
				bypass_reg <= 1'b0;
			else if (inCapDr && sel.bypass)
				bypass_reg <= 1'b0;
			else if (inShDr && sel.bypass)
				bypass_reg <= tdi;
			if (inCapDr && use32)
				dr32_reg <= dr32Cap;
			else if (inShDr && use32)
				dr32_reg <= {tdi, dr32_reg[`JTDEC_DR_W-1:1]};
			if (inCapDr && sel.bscan)
				bsc_reg <= bscanCapture;
			else if (inShDr && sel.bscan)
				bsc_reg <= {tdi, bsc_reg[CHAIN_W-1:1]};
		end

	// ------------------------------------------------------------
	// falling-edge outputs
	// ------------------------------------------------------------
	wire drBit = sel.bscan ? bsc_reg[0] : use32 ? dr32_reg[0] : sel.userA ? userATdo
		: sel.userB ? userBTdo : bypass_reg;
	wire tdoSrc = inShIr ? irShift_reg[0] : drBit;
	logic cfgStb_reg;
	logic startCfg_meta;
	logic startCfg_reg;
	// serial output moves on the falling edge so the tester samples a settled bit
	always_ff @(negedge tck or posedge sys_rst)
		if (sys_rst)
		begin
			tdoOut <= 1'b0;
			tdoOe <= 1'b0;
		end
		else
		begin
			tdoOut <= tdoSrc;
			tdoOe <= inShIr || inShDr;
		end

	// update latches open with the test clock low in update-data
	always_ff @(negedge tck or posedge sys_rst)
		if (sys_rst)
		begin
			bscanUpdate <= '0;
			cfgWord <= '0;
			cfgStb_reg <= 1'b0;
		end
		else
		begin
			if (inUpdDr && sel.bscan)
				bscanUpdate <= bsc_reg;
			if (inUpdDr && sel.cfgWr)
			begin
				cfgWord <= dr32_reg;
				cfgStb_reg <= !cfgStb_reg;
			end
		end

	// mode flags follow the held opcode; the startup source is synchronised first
	always_ff @(negedge tck or posedge sys_rst)
		if (sys_rst)
		begin
			userASel <= 1'b0;
			userBSel <= 1'b0;
			shiftDr <= 1'b0;
			updateDr <= 1'b0;
			floatOutputs <= 1'b0;
			bscanMode <= 1'b0;
			startupStep <= 1'b0;
			tapReset <= 1'b1;
			startCfg_meta <= 1'b0;
			startCfg_reg <= 1'b0;
		end
		else
		begin
			userASel <= sel.userA;
			userBSel <= sel.userB;
			shiftDr <= inShDr;
			updateDr <= inUpdDr;
			floatOutputs <= sel.floatOut;
			bscanMode <= sel.bscan;
			startCfg_meta <= startClkIsTck;
			startCfg_reg <= startCfg_meta;
			startupStep <= sel.start && startCfg_reg && (state_reg == jtdec_pkg::RTI);
			tapReset <= inTlr;
		end
	assign cfgWordStb = cfgStb_reg;
endmodule

// ==== tb/jtdec_tap_checker.sv ====
// port-level assertions for the tap instruction decoder
module jtdec_tap_checker (
	input wire logic clk, // system clock
	input wire logic sys_rst, // reset, both domains
	input wire logic tck, // test clock
	input wire logic tms, // mode select
	input wire logic tdoOe, // serial out enable
	input wire logic shiftDr, // data shift
	input wire logic updateDr, // update-data state
	input wire logic floatOutputs, // outputs float
	input wire logic bscanMode, // boundary mode
	input wire logic userASel, // user reg a
	input wire logic userBSel, // user reg b
	input wire logic startupStep, // startup step
	input wire logic cfgWordStb, // config word toggle
	input wire logic tapReset, // test-logic-reset
	input wire logic configDone, // configured
	input wire logic configDoneSys // configured, clk copy
);
	timeunit 1ns;
	timeprecision 100ps;
	// outputs move on the falling edge, so rising-edge samples see settled values
	tms_reset_a: assert property (@(posedge tck) disable iff (sys_rst)
		tms [*5] |=> tapReset) else $error("five mode highs left controller out of reset");
	shift_entry_a: assert property (@(posedge tck) disable iff (sys_rst)
		$rose(tdoOe) |-> !$past(tms)) else $error("output enabled off a shift");
	shift_hold_a: assert property (@(posedge tck) disable iff (sys_rst)
		tdoOe && !tms |=> tdoOe) else $error("output dropped while still shifting");
	dr_shift_oe_a: assert property (@(posedge tck) disable iff (sys_rst)
		shiftDr |-> tdoOe) else $error("data shift without output enable");
	update_pulse_a: assert property (@(posedge tck) disable iff (sys_rst)
		updateDr |=> !updateDr) else $error("update-data held past one edge");
	update_entry_a: assert property (@(posedge tck) disable iff (sys_rst)
		$rose(updateDr) |-> $past(tms)) else $error("update-data entered with mode low");
	one_select_a: assert property (@(posedge tck) disable iff (sys_rst)
		$onehot0({bscanMode, userASel, userBSel, floatOutputs})) else $error("two selects at once");
	startup_idle_a: assert property (@(posedge tck) disable iff (sys_rst)
		startupStep |-> !tdoOe && !shiftDr) else $error("startup step outside idle");
	cfg_strobe_a: assert property (@(posedge tck) disable iff (sys_rst)
		$changed(cfgWordStb) |-> updateDr) else $error("config word strobe outside update");
	cfg_sync_a: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(configDoneSys) |-> $past(configDone)) else $error("configured copy rose alone");
	cover property (@(posedge tck) disable iff (sys_rst) userASel);
	cover property (@(posedge tck) disable iff (sys_rst) startupStep);
	cover property (@(posedge tck) disable iff (sys_rst) $changed(cfgWordStb));
endmodule

// ==== tb/jtdec_host.sv ====
// external test controller model: drives the test clock only within frames
module jtdec_host (
	output logic tck, // test clock, still between steps
	output logic tms, // mode select
	output logic tdi, // serial data to the tap
	input wire logic tdoOut, // serial data from the tap
	input wire logic tdoOe // tap output enable
);
	timeunit 1ns;
	timeprecision 100ps;
	logic lastTdo = 1'b0;
	// a floating line must not show a stale bit, so it reads inverted
	wire logic tdoLine = tdoOe ? tdoOut : ~lastTdo;
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#3.75;
		q = tdoLine;
		lastTdo = q;
		tck = 1'b1;
		#7.5;
		tck = 1'b0;
		#3.75;
	endtask
endmodule

// ==== tb/test_jtdec_tap.sv ====
// self-checking bench for the tap instruction decoder
module test_jtdec_tap;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] IDENT = 32'h0bad_c0d1; // arbitrary value
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic configDone = 1'b0;
	logic startClkIsTck = 1'b0;
	logic [31:0] user_code_instr = 32'h5a3c_96e1;
	logic [2:0] devStatus = 3'h0;
	logic userATdo = 1'b0;
	logic userBTdo = 1'b0;
	logic [2:0] bscanCapture = 3'h0;
	logic tck, tms, tdi, tdoOut, tdoOe, tapReset, userASel, userBSel, shiftDr, updateDr, b;
	logic floatOutputs, bscanMode, startupStep, cfgWordStb, configDoneSys, chk;
	logic [2:0] bscanUpdate;
	logic [31:0] cfgWord, d, e, q, r;
	int seed;
	int n_fail = 0;
	int total_checks = 0;
	int n;
	always #4 clk = ~clk;
	jtdec_host jtdec_host_inst (
		.tck(tck),
		.tms(tms),
		.tdi(tdi),
		.tdoOut(tdoOut),
		.tdoOe(tdoOe)
	);
	jtdec_tap #(.IDENT_CODE(IDENT), .CHAIN_W(3)) jtdec_tap_inst (
		.clk(clk),
		.sys_rst(sys_rst),
		.tck(tck),
		.tms(tms),
		.tdi(tdi),
		.tdoOut(tdoOut),
		.tdoOe(tdoOe),
		.configDone(configDone),
		.startClkIsTck(startClkIsTck),
		.user_code_instr(user_code_instr),
		.devStatus(devStatus),
		.userATdo(userATdo),
		.userBTdo(userBTdo),
		.bscanCapture(bscanCapture),
		.bscanUpdate(bscanUpdate),
		.cfgWord(cfgWord),
		.cfgWordStb(cfgWordStb),
		.userASel(userASel),
		.userBSel(userBSel),
		.shiftDr(shiftDr),
		.updateDr(updateDr),
		.floatOutputs(floatOutputs),
		.bscanMode(bscanMode),
		.startupStep(startupStep),
		.tapReset(tapReset),
		.configDoneSys(configDoneSys)
	);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// one scan from idle back to idle, lsb first, mode high on the last bit
	task automatic scan(input logic ir, input logic [31:0] dv, input int len, output logic [31:0] qv);
		qv = 32'h0000_0000;
		jtdec_host_inst.step(1'b1, 1'b0, b);
		if (ir)
			jtdec_host_inst.step(1'b1, 1'b0, b);
		jtdec_host_inst.step(1'b0, 1'b0, b);
		jtdec_host_inst.step(1'b0, 1'b0, b);
		for (int i = 0; i < len; i++)
		begin
			jtdec_host_inst.step(i == len - 1, dv[i], b);
			qv[i] = b;
		end
		jtdec_host_inst.step(1'b1, 1'b0, b);
		jtdec_host_inst.step(1'b0, 1'b0, b);
	endtask
	task automatic idCheck;
		repeat (5) jtdec_host_inst.step(1'b1, 1'b1, b);
		check("tapReset", 32'(tapReset), 32'h1);
		jtdec_host_inst.step(1'b0, 1'b1, b);
		scan(1'b0, 32'h0000_0000, 32, q);
		check("ident", q, IDENT);
	endtask
	function automatic logic [4:0] selExp(input logic [4:0] op);
		return {op == 5'h00 || op == 5'h01 || op == 5'h07, configDone && op == 5'h02,
			configDone && op == 5'h03, op == 5'h0a, startClkIsTck && op == 5'h0c};
	endfunction
	function automatic logic [31:0] expDr(input logic [4:0] op, output int len, output logic cmp);
		len = (op inside {5'h00, 5'h01, 5'h07}) ? 3 : (op inside {[5'h04:5'h05], [5'h08:5'h09]}) ? 32 : 2;
		cmp = op != 5'h04 && op != 5'h05;
		expDr = {30'h0, d[0], 1'b0};
		case (op)
			5'h00, 5'h01, 5'h07: expDr = {29'h0, bscanCapture};
			5'h02: if (configDone) expDr = {30'h0, {2{userATdo}}};
			5'h03: if (configDone) expDr = {30'h0, {2{userBTdo}}};
			5'h08: expDr = user_code_instr;
			5'h09: expDr = IDENT;
			default: ;
		endcase
	endfunction
	initial
	begin
		seed = 32'h8f65;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		check("tdoOe", 32'(tdoOe), 32'h0);
		idCheck;
		// every opcode once before and once after configuration
		for (int k = 0; k < 64; k++)
		begin
			@(posedge clk);
			r = $random(seed);
			configDone <= k[5];
			startClkIsTck <= r[0];
			devStatus <= r[3:1];
			userATdo <= r[4];
			userBTdo <= r[5];
			bscanCapture <= r[8:6];
			d = $random(seed);
			repeat (3) @(posedge clk);
			scan(1'b1, {27'h0, k[4:0]}, 5, q);
			check("irCapture", q, {27'h0, devStatus, 2'b01});
			check("decode", 32'({bscanMode, userASel, userBSel, floatOutputs, startupStep}),
				32'(selExp(k[4:0])));
			e = expDr(k[4:0], n, chk);
			scan(1'b0, d, n, q);
			if (chk) check("dr", q, e);
			if (k[4:0] == 5'h05) check("cfgWord", cfgWord, d);
			if (k[4:0] == 5'h05) check("cfgWordStb", 32'(cfgWordStb), 32'(!k[5]));
			check("configDoneSys", 32'(configDoneSys), 32'(k[5]));
			if (n == 3) check("bscanUpdate", 32'(bscanUpdate), 32'(d[2:0]));
		end
		idCheck;
		report_and_stop;
	end
	initial
	begin
		#400000;
		n_fail++;
		report_and_stop;
	end
endmodule
bind jtdec_tap jtdec_tap_checker jtdec_tap_checker_inst (
	.clk(clk),
	.sys_rst(sys_rst),
	.tck(tck),
	.tms(tms),
	.tdoOe(tdoOe),
	.shiftDr(shiftDr),
	.updateDr(updateDr),
	.floatOutputs(floatOutputs),
	.bscanMode(bscanMode),
	.userASel(userASel),
	.userBSel(userBSel),
	.startupStep(startupStep),
	.cfgWordStb(cfgWordStb),
	.tapReset(tapReset),
	.configDone(configDone),
	.configDoneSys(configDoneSys)
);
